/* File: adc_event_flag_registers.sv */
// ADC event flag register bank behind an AXI4-Lite slave.
// Event inputs come from logic on aclk and are not synchronised.
//
// Summary of operation
// - Left overflow sets sticky bit 3 until read
// - Right overflow sets sticky bit 2 until read
// - Shifter overflow sets sticky bit 1 until read
// - Reading sticky register clears it; writes ignored
// - Cleared flag re-sets only on new trigger
// - Live overflow register shows bits 3..1 directly
// - Sticky left noise flag at bit 6
// - Sticky right noise flag at bit 5
// - Sticky DSP interrupt ports at bits 4, 3
// - Live DSP port values at bits 4, 3
// - Live noise flags at bits 6, 5
// - Output pin selects interrupt A or B
`timescale 1ns/1ps

module adc_event_flag_registers #(
	parameter int ADDR_W = 8
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [ADDR_W-1:0]      awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [ADDR_W-1:0]      araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire adc_flag_pkg::event_t   event_i,
	output logic                        irq,
	output logic                        interrupt_out_a,
	output logic                        interrupt_out_b,
	output logic                        serial_out_pin
);

	// Elaboration check: the register map needs at least eight address bits
	if (ADDR_W < 8) begin : g_addr_w_chk
		$error("ADDR_W must be at least 8");
	end

	// ------------------------------------------------------------
	// Bus state
	// ------------------------------------------------------------
	logic                aw_hold_r, aw_hold_nxt;
	logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
	logic                w_hold_r, w_hold_nxt;
	logic [7:0]          wbyte_r, wbyte_nxt;
	logic                wlane_r, wlane_nxt;
	logic                bvalid_r, bvalid_nxt;
	logic [1:0]          bresp_r, bresp_nxt;
	logic                rvalid_r, rvalid_nxt;
	logic [7:0]          rdata_r, rdata_nxt;
	logic [1:0]          rresp_r, rresp_nxt;
	logic                rd_fire, do_wr;

	// ------------------------------------------------------------
	// Flag and control state
	// ------------------------------------------------------------
	adc_flag_pkg::event_t sticky_r, sticky_nxt;
	adc_flag_pkg::event_t stat_r, stat_nxt;
	adc_flag_pkg::event_t en_r, en_nxt;
	logic [2:0]           pin_fn_r, pin_fn_nxt;
	logic                 pin_r, pin_nxt;
	logic [6:0]           rd_clr;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
		byte_addr = ADDR_W'({idx, 2'b00});
	endfunction

	assign awready = !aw_hold_r && !bvalid_r;
	assign wready  = !w_hold_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = {24'h000000, rdata_r};

	assign rd_fire = arvalid && arready;
	assign do_wr   = aw_hold_r && w_hold_r;

	// ------------------------------------------------------------
	// Bus handshakes, read decode and write response
	// ------------------------------------------------------------
	// Address and data are parked separately so either may come first;
	// the write lands one cycle after both are held.
	always_comb begin
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt  = awaddr_r;
		w_hold_nxt  = w_hold_r;
		wbyte_nxt   = wbyte_r;
		wlane_nxt   = wlane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		rd_clr      = 7'h00;
		if (awvalid && awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_nxt = 1'b1;
			wbyte_nxt  = wdata[7:0];
			wlane_nxt  = wstrb[0];
		end
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = adc_flag_pkg::RESP_OKAY;
			// Unmapped addresses answer SLVERR; read-only ones drop the data
			unique case (awaddr_r)
				byte_addr(adc_flag_pkg::IDX_STICKY_OVF),
				byte_addr(adc_flag_pkg::IDX_LIVE_OVF),
				byte_addr(adc_flag_pkg::IDX_RSVD_A),
				byte_addr(adc_flag_pkg::IDX_STICKY_ADC),
				byte_addr(adc_flag_pkg::IDX_RSVD_B),
				byte_addr(adc_flag_pkg::IDX_LIVE_ADC),
				byte_addr(adc_flag_pkg::IDX_IRQ_STAT),
				byte_addr(adc_flag_pkg::IDX_IRQ_CLR),
				byte_addr(adc_flag_pkg::IDX_IRQ_EN),
				byte_addr(adc_flag_pkg::IDX_PIN_CTRL): bresp_nxt = adc_flag_pkg::RESP_OKAY;
				default: bresp_nxt = adc_flag_pkg::RESP_SLVERR;
			endcase
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (rd_fire) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = adc_flag_pkg::RESP_OKAY;
			rdata_nxt  = 8'h00;
			unique case (araddr)
				byte_addr(adc_flag_pkg::IDX_STICKY_OVF): begin
					rdata_nxt = {4'h0, sticky_r.ovf_left, sticky_r.ovf_right,
						sticky_r.ovf_shift, 1'b0};
					rd_clr    = adc_flag_pkg::MASK_OVF;
				end
				byte_addr(adc_flag_pkg::IDX_LIVE_OVF): begin
					rdata_nxt = {4'h0, event_i.ovf_left, event_i.ovf_right,
						event_i.ovf_shift, 1'b0};
				end
				byte_addr(adc_flag_pkg::IDX_STICKY_ADC): begin
					rdata_nxt = {1'b0, sticky_r.noise_left, sticky_r.noise_right,
						sticky_r.dsp_std, sticky_r.dsp_aux, 3'h0};
					rd_clr    = adc_flag_pkg::MASK_ADC;
				end
				byte_addr(adc_flag_pkg::IDX_LIVE_ADC): begin
					// Sampled in the cycle the address is taken
					rdata_nxt = {1'b0, event_i.noise_left, event_i.noise_right,
						event_i.dsp_std, event_i.dsp_aux, 3'h0};
				end
				byte_addr(adc_flag_pkg::IDX_RSVD_A),
				byte_addr(adc_flag_pkg::IDX_RSVD_B),
				byte_addr(adc_flag_pkg::IDX_IRQ_CLR): rdata_nxt = 8'h00;
				byte_addr(adc_flag_pkg::IDX_IRQ_STAT): rdata_nxt = {1'b0, stat_r};
				byte_addr(adc_flag_pkg::IDX_IRQ_EN): rdata_nxt = {1'b0, en_r};
				byte_addr(adc_flag_pkg::IDX_PIN_CTRL): rdata_nxt = {5'h00, pin_fn_r};
				default: rresp_nxt = adc_flag_pkg::RESP_SLVERR;
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// Bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= '0;
			w_hold_r  <= 1'b0;
			wbyte_r   <= 8'h00;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= adc_flag_pkg::RESP_OKAY;
			rvalid_r  <= 1'b0;
			rdata_r   <= 8'h00;
			rresp_r   <= adc_flag_pkg::RESP_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			awaddr_r  <= awaddr_nxt;
			w_hold_r  <= w_hold_nxt;
			wbyte_r   <= wbyte_nxt;
			wlane_r   <= wlane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// ------------------------------------------------------------
	// Sticky flags, interrupt status and control
	// ------------------------------------------------------------
	// Set is ORed in after the clear so a trigger in the read cycle survives.
	always_comb begin
		sticky_nxt = (sticky_r & ~rd_clr) | event_i;
		stat_nxt   = stat_r | event_i;
		en_nxt     = en_r;
		pin_fn_nxt = pin_fn_r;
		if (do_wr && wlane_r) begin
			unique case (awaddr_r)
				byte_addr(adc_flag_pkg::IDX_IRQ_CLR):
					stat_nxt = (stat_r & ~wbyte_r[6:0]) | event_i;
				byte_addr(adc_flag_pkg::IDX_IRQ_EN): en_nxt = wbyte_r[6:0];
				byte_addr(adc_flag_pkg::IDX_PIN_CTRL): pin_fn_nxt = wbyte_r[2:0];
				default: en_nxt = en_r; // Read-only and unmapped words ignore data
			endcase
		end
	end

	assign interrupt_out_a = |(stat_r & en_r);
	assign interrupt_out_b = |sticky_r;
	assign irq             = interrupt_out_a;

	// Pin function mux; codes other than the two interrupts drive low
	always_comb begin
		unique case (pin_fn_r)
			adc_flag_pkg::PIN_FN_INT_A: pin_nxt = interrupt_out_a;
			adc_flag_pkg::PIN_FN_INT_B: pin_nxt = interrupt_out_b;
			default: pin_nxt = 1'b0;
		endcase
	end

	assign serial_out_pin = pin_r;

	// Flag registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sticky_r <= adc_flag_pkg::FLAGS_RST;
			stat_r   <= adc_flag_pkg::FLAGS_RST;
			en_r     <= adc_flag_pkg::FLAGS_RST;
			pin_fn_r <= adc_flag_pkg::PIN_FN_RST;
			pin_r    <= 1'b0;
		end else begin
			sticky_r <= sticky_nxt;
			stat_r   <= stat_nxt;
			en_r     <= en_nxt;
			pin_fn_r <= pin_fn_nxt;
			pin_r    <= pin_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic rd_ovf, rd_adc, rd_lovf, rd_ladc;
	assign rd_ovf  = rd_fire && araddr == byte_addr(adc_flag_pkg::IDX_STICKY_OVF);
	assign rd_adc  = rd_fire && araddr == byte_addr(adc_flag_pkg::IDX_STICKY_ADC);
	assign rd_lovf = rd_fire && araddr == byte_addr(adc_flag_pkg::IDX_LIVE_OVF);
	assign rd_ladc = rd_fire && araddr == byte_addr(adc_flag_pkg::IDX_LIVE_ADC);

	AST_LEFT_HELD: assert property (
		event_i.ovf_left ##1 !rd_ovf [*3] |=> sticky_r.ovf_left)
		else $error("left overflow flag lost before read");
	AST_RIGHT_SET: assert property (
		event_i.ovf_right |=> sticky_r.ovf_right)
		else $error("right overflow flag not set");
	AST_SHIFT_READ: assert property (
		event_i.ovf_shift ##1 rd_ovf |=> rdata_r[adc_flag_pkg::BIT_OVF_SHIFT])
		else $error("shifter overflow not reported by read");
	AST_CLEAR_ON_READ: assert property (
		rd_ovf && !event_i.ovf_left && !event_i.ovf_right && !event_i.ovf_shift
		|=> sticky_r.ovf_left == 1'b0 && sticky_r.ovf_right == 1'b0
			&& sticky_r.ovf_shift == 1'b0)
		else $error("overflow flags not cleared by read");
	AST_NO_SPURIOUS: assert property (
		!sticky_r.noise_left && !event_i.noise_left |=> !sticky_r.noise_left)
		else $error("noise flag set without trigger");
	AST_LIVE_OVF: assert property (
		rd_lovf |=> rvalid_r && rdata_r[3:1] == $past(event_i[2:0]))
		else $error("live overflow read mismatch");
	AST_NOISE_STICKY: assert property (
		event_i.noise_left ##1 rd_adc |=> rdata_r[adc_flag_pkg::BIT_NOISE_LEFT])
		else $error("left noise flag not reported");
	AST_NOISE_RIGHT: assert property (
		event_i.noise_right |=> sticky_r.noise_right)
		else $error("right noise flag not set");
	AST_DSP_STICKY: assert property (
		rd_adc |=> rdata_r[4:3] == $past(sticky_r[4:3]))
		else $error("dsp sticky bits misreported");
	AST_LIVE_ADC: assert property (
		rd_ladc |=> rdata_r[6:3] == $past(event_i[6:3]) && rdata_r[2:0] == 3'h0)
		else $error("live adc read mismatch");
	AST_LIVE_NOISE: assert property (
		rd_ladc && event_i.noise_right |=> rdata_r[adc_flag_pkg::BIT_NOISE_RIGHT])
		else $error("live right noise not shown");
	AST_PIN_SELECT: assert property (
		pin_fn_r == adc_flag_pkg::PIN_FN_INT_B && $stable(pin_fn_r)
		|=> serial_out_pin == $past(interrupt_out_b))
		else $error("pin does not follow interrupt b");
	AST_SET_WINS: assert property (
		rd_adc && event_i.dsp_aux |=> sticky_r.dsp_aux)
		else $error("event lost in clearing read");

	// Flags only leave through a clearing read of their own register
	AST_WRITE_IGNORED: assert property (
		do_wr && !rd_fire |=> sticky_r == ($past(sticky_r) | $past(event_i)))
		else $error("write changed sticky flags");
	AST_ADC_CLEAR: assert property (
		rd_adc && event_i[6:3] == 4'h0 |=> sticky_r[6:3] == 4'h0)
		else $error("adc flags not cleared by read");
	AST_READ_NO_SET: assert property (
		rd_fire && event_i == 7'h00 |=> (sticky_r & ~$past(sticky_r)) == 7'h00)
		else $error("read set a sticky flag");
	AST_LIVE_NO_CLEAR: assert property (
		rd_lovf |=> sticky_r == ($past(sticky_r) | $past(event_i)))
		else $error("live read disturbed sticky flags");
	AST_LEFT_SET: assert property (
		event_i.ovf_left |=> sticky_r.ovf_left)
		else $error("left overflow flag not set");
	AST_SHIFT_SET: assert property (
		event_i.ovf_shift |=> sticky_r.ovf_shift)
		else $error("shifter overflow flag not set");
	AST_DSP_STD_SET: assert property (
		event_i.dsp_std |=> sticky_r.dsp_std)
		else $error("dsp standard flag not set");
	AST_DSP_AUX_SET: assert property (
		event_i.dsp_aux |=> sticky_r.dsp_aux)
		else $error("dsp auxiliary flag not set");
	// Pin follows the selected interrupt one cycle late, otherwise low
	AST_PIN_INT_A: assert property (
		pin_fn_r == adc_flag_pkg::PIN_FN_INT_A |=> serial_out_pin == $past(interrupt_out_a))
		else $error("pin does not follow interrupt a");
	AST_PIN_OTHER: assert property (
		pin_fn_r != adc_flag_pkg::PIN_FN_INT_A && pin_fn_r != adc_flag_pkg::PIN_FN_INT_B
		|=> !serial_out_pin)
		else $error("pin not low for other functions");

endmodule // adc_event_flag_registers

/* File: adc_flag_pkg.sv */
// Constants and types shared by the ADC event flag register bank.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package adc_flag_pkg;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_STICKY_OVF = 6'h2a;
	localparam logic [5:0] IDX_LIVE_OVF   = 6'h2b;
	localparam logic [5:0] IDX_RSVD_A     = 6'h2c;
	localparam logic [5:0] IDX_STICKY_ADC = 6'h2d;
	localparam logic [5:0] IDX_RSVD_B     = 6'h2e;
	localparam logic [5:0] IDX_LIVE_ADC   = 6'h2f;
	localparam logic [5:0] IDX_IRQ_STAT   = 6'h30;
	localparam logic [5:0] IDX_IRQ_CLR    = 6'h31;
	localparam logic [5:0] IDX_IRQ_EN     = 6'h32;
	localparam logic [5:0] IDX_PIN_CTRL   = 6'h35;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_OVF_LEFT    = 3;
	localparam int BIT_OVF_RIGHT   = 2;
	localparam int BIT_OVF_SHIFT   = 1;
	localparam int BIT_NOISE_LEFT  = 6;
	localparam int BIT_NOISE_RIGHT = 5;
	localparam int BIT_DSP_STD     = 4;
	localparam int BIT_DSP_AUX     = 3;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [6:0] FLAGS_RST     = 7'h00;
	localparam logic [2:0] PIN_FN_RST    = 3'h1;
	localparam logic [2:0] PIN_FN_INT_A  = 3'h4;
	localparam logic [2:0] PIN_FN_INT_B  = 3'h5;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	localparam logic [6:0] MASK_OVF      = 7'h07;
	localparam logic [6:0] MASK_ADC      = 7'h78;

	// One bit per event source, same layout in status and enable
	typedef struct packed {
		logic noise_left;
		logic noise_right;
		logic dsp_std;
		logic dsp_aux;
		logic ovf_left;
		logic ovf_right;
		logic ovf_shift;
	} event_t;

endpackage

/* File: tb_top.sv */
// Self-checking testbench for the ADC event flag register bank.
// Assumes the design package is compiled first and a 100 MHz clock.
`timescale 1ns/1ps

module tb_top;

	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
	logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                  arvalid = 1'b0, rready = 1'b0;
	logic [31:0]           wdata = 32'h0;
	logic [3:0]            wstrb = 4'h0;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, rs;
	logic [31:0]           rdata, rd;
	adc_flag_pkg::event_t  event_i = '0;
	logic                  irq, interrupt_out_a, interrupt_out_b, serial_out_pin;
	int                    fails = 0;
	int                    cmp_count = 0;

	adc_event_flag_registers u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.event_i(event_i), .irq(irq), .interrupt_out_a(interrupt_out_a),
		.interrupt_out_b(interrupt_out_b), .serial_out_pin(serial_out_pin));

	// Free-running 10 ns clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Each bus task waits an edge first, so no strobe is driven twice in one step
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 50) begin
			fails++;
			report_and_stop();
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 50) begin
			fails++;
			report_and_stop();
		end
	endtask

	// One-cycle event pulse, sampled at the second edge
	task automatic pulse(input logic [6:0] ev);
		@(posedge aclk);
		event_i <= adc_flag_pkg::event_t'(ev);
		@(posedge aclk);
		event_i <= '0;
	endtask

	// Called right after an edge: reset is sampled low at exactly five edges
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Table of ordinary cases: event, hold during read, address, data
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [6:0] ev;
		logic       hold;
		logic [7:0] addr;
		logic [7:0] exp;
	} row_t;

	row_t rows [18] = '{
		'{7'h04, 1'b0, 8'ha8, 8'h08}, '{7'h00, 1'b0, 8'ha8, 8'h00},
		'{7'h02, 1'b0, 8'ha8, 8'h04}, '{7'h01, 1'b0, 8'ha8, 8'h02},
		'{7'h40, 1'b0, 8'hb4, 8'h40}, '{7'h20, 1'b0, 8'hb4, 8'h20},
		'{7'h18, 1'b0, 8'hb4, 8'h18}, '{7'h07, 1'b1, 8'hac, 8'h0e},
		'{7'h00, 1'b0, 8'ha8, 8'h0e}, '{7'h41, 1'b1, 8'hb4, 8'h40},
		'{7'h41, 1'b1, 8'ha8, 8'h02}, '{7'h00, 1'b0, 8'ha8, 8'h02},
		'{7'h00, 1'b0, 8'hb4, 8'h40}, '{7'h68, 1'b1, 8'hbc, 8'h68},
		'{7'h00, 1'b0, 8'hb4, 8'h68}, '{7'h00, 1'b0, 8'hbc, 8'h00},
		'{7'h00, 1'b0, 8'hb0, 8'h00}, '{7'h00, 1'b0, 8'hb8, 8'h00}
	};

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		@(posedge aclk);
		#1;
		check("irq after reset", {31'h0, irq}, 32'h0);
		check("flag pin after reset", {31'h0, interrupt_out_b}, 32'h0);
		check("serial pin after reset", {31'h0, serial_out_pin}, 32'h0);
		axi_read(8'hd4, rd, rs);
		check("pin control reset", rd, {29'h0, adc_flag_pkg::PIN_FN_RST});

		// Table loop; held events stay high across the read
		foreach (rows[i]) begin
			if (rows[i].hold) begin
				@(posedge aclk);
				event_i <= adc_flag_pkg::event_t'(rows[i].ev);
			end else begin
				pulse(rows[i].ev);
			end
			axi_read(rows[i].addr, rd, rs);
			event_i <= '0;
			check("table read", rd, {24'h0, rows[i].exp});
			check("table resp", {30'h0, rs}, {30'h0, adc_flag_pkg::RESP_OKAY});
		end

		// A write to a sticky register must not clear it
		pulse(7'h04);
		axi_write(8'ha8, 32'hff, rs);
		axi_read(8'ha8, rd, rs);
		check("sticky after write", rd, 32'h08);
		axi_read(8'ha8, rd, rs);
		check("sticky after read", rd, 32'h00);

		// Trigger only at the edge that takes the clearing read: the read
		// misses it, yet the flag must survive the clear
		fork
			axi_read(8'hb4, rd, rs);
			pulse(7'h08);
		join
		check("collide first read", rd, 32'h00);
		axi_read(8'hb4, rd, rs);
		check("collide kept", rd, 32'h08);
		axi_read(8'hb4, rd, rs);
		check("collide cleared", rd, 32'h00);

		// Unmapped and misaligned addresses
		axi_read(8'hfc, rd, rs);
		check("unmapped read resp", {30'h0, rs}, {30'h0, adc_flag_pkg::RESP_SLVERR});
		check("unmapped read data", rd, 32'h0);
		axi_read(8'ha9, rd, rs);
		check("misaligned resp", {30'h0, rs}, {30'h0, adc_flag_pkg::RESP_SLVERR});
		axi_write(8'hfc, 32'h1, rs);
		check("unmapped write resp", {30'h0, rs}, {30'h0, adc_flag_pkg::RESP_SLVERR});

		// Interrupt raise, mask, unmask, clear; pin function selects
		axi_write(8'hc8, 32'h04, rs);
		pulse(7'h04);
		axi_write(8'hd4, {29'h0, adc_flag_pkg::PIN_FN_INT_A}, rs);
		#1;
		check("irq raised", {31'h0, irq}, 32'h1);
		check("pin shows int a", {31'h0, serial_out_pin}, 32'h1);
		axi_write(8'hc8, 32'h00, rs);
		@(posedge aclk);
		#1;
		check("irq masked", {31'h0, irq}, 32'h0);
		check("pin follows int a", {31'h0, serial_out_pin}, 32'h0);
		axi_write(8'hc8, 32'h04, rs);
		#1;
		check("irq unmasked", {31'h0, interrupt_out_a}, 32'h1);
		axi_write(8'hc4, 32'h7f, rs);
		#1;
		check("irq cleared", {31'h0, irq}, 32'h0);
		axi_write(8'hd4, {29'h0, adc_flag_pkg::PIN_FN_INT_B}, rs);
		@(posedge aclk);
		#1;
		check("pin shows int b", {31'h0, serial_out_pin}, 32'h1);
		axi_read(8'ha8, rd, rs);
		@(posedge aclk);
		#1;
		check("int b after read", {31'h0, interrupt_out_b}, 32'h0);
		check("pin follows int b", {31'h0, serial_out_pin}, 32'h0);

		// Reset in mid-run drops a pending flag
		pulse(7'h40);
		do_reset();
		axi_read(8'hb4, rd, rs);
		check("flag after reset", rd, 32'h0);
		report_and_stop();
	end

endmodule // tb_top
